// [pbri_ctrl.sv]
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pbri_ctrl
    import pbri_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Bus master side
    input  wire pbri_req_t   req,
    input  wire logic        req_valid,
    output logic             req_taken,
    output logic             resp_valid,
    output logic      [31:0] resp_rdata,
    // Memory side
    output pbri_pins_t       mem,
    input  wire logic [31:0] mem_din,
    input  wire logic        wait_n
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] beats_of(input logic [1:0] sz, input logic w16);
        if (sz == 2'h2) begin
            beats_of = w16 ? 3'h2 : 3'h4;
        end else if (sz == 2'h1) begin
            beats_of = w16 ? 3'h1 : 3'h2;
        end else begin
            beats_of = 3'h1;
        end
    endfunction

    function automatic logic [1:0] s3_waits(input logic [1:0] w);
        s3_waits = (w > S3_WAIT_MAX) ? S3_WAIT_MAX : w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [5:0]  memctl_r;
    logic [3:0]  waitctl_r;
    logic [4:0]  busctl_r;
    logic [2:0]  clksel_r;
    logic [7:0]  rcount_r;
    logic [7:0]  rmatch_r;
    logic [11:0] presc_r;
    logic        rf_pend_r;
    pbri_state_t state_r;
    pbri_state_t state_nxt;
    logic [2:0]  cnt_r;
    logic [2:0]  cnt_nxt;
    logic        op_refresh_on_r;
    pbri_req_t   op_r;
    logic [26:0] rom_addr_r;
    logic [2:0]  beats_r;
    logic [1:0]  longs_r;
    logic [31:0] shift_r;
    logic [31:0] resp_rdata_r;
    logic        resp_valid_r;
    logic [31:0] reg_rdata_r;
    logic        take_idle;
    logic        take_capt;
    logic        null_done;
    logic        beat_end;

    wire logic       is_psram  = (busctl_r[2:0] == TYPE_PSRAM);
    wire logic       self_req  = memctl_r[MC_KIND] & memctl_r[MC_ON];
    wire logic       auto_on   = ~memctl_r[MC_KIND] & memctl_r[MC_ON];
    wire logic       nibble    = busctl_r[BC_NIBBLE];
    wire logic       rom16     = busctl_r[BC_ROM16];
    wire logic [1:0] w3        = s3_waits(waitctl_r[1:0]);
    wire logic [1:0] w0        = waitctl_r[3:2];
    wire logic [2:0] rf_len    = memctl_r[MC_LEN] ? RF_LEN_LONG : RF_LEN_SHORT;
    wire logic       cnt_wr    = reg_wr && (reg_addr == REG_RCOUNT);
    wire logic       matched   = (clksel_r != 3'h0) && (rcount_r == rmatch_r);
    wire logic       tick      = (clksel_r != 3'h0)
                                 && ((presc_r & DIV_MASK[clksel_r]) == DIV_MASK[clksel_r]);
    wire logic       same_row  = (req.addr[26:ROW_LSB] == op_r.addr[26:ROW_LSB]);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; software orders its writes itself
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            memctl_r  <= MEMCTL_RST;
            waitctl_r <= WAITCTL_RST;
            busctl_r  <= BUSCTL_RST;
            clksel_r  <= 3'h0;
            rmatch_r  <= RMATCH_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_MEMCTL:  memctl_r  <= reg_wdata[5:0];
                REG_WAITCTL: waitctl_r <= reg_wdata[3:0];
                REG_BUSCTL:  busctl_r  <= reg_wdata[4:0];
                REG_RTCTL:   clksel_r  <= reg_wdata[2:0];
                REG_RMATCH:  rmatch_r  <= reg_wdata[7:0];
                default:     memctl_r  <= memctl_r;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_MEMCTL:  reg_rdata_r <= {26'h0, memctl_r};
                REG_WAITCTL: reg_rdata_r <= {28'h0, waitctl_r};
                REG_BUSCTL:  reg_rdata_r <= {27'h0, busctl_r};
                REG_RTCTL:   reg_rdata_r <= {29'h0, clksel_r};
                REG_RCOUNT:  reg_rdata_r <= {24'h0, rcount_r};
                REG_RMATCH:  reg_rdata_r <= {24'h0, rmatch_r};
                REG_STATUS:  reg_rdata_r <= {28'h0, state_r == ST_RECOV, rf_pend_r,
                                             state_r == ST_SELF, state_r != ST_IDLE};
                default:     reg_rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_r <= 32'h0000_0000;
        end
    end
    assign reg_rdata = reg_rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Refresh timer; prescaler runs free so a new select starts mid-phase
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            presc_r <= 12'h000;
        end else begin
            presc_r <= presc_r + 12'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rcount_r <= RCOUNT_RST;
        end else if (cnt_wr) begin
            rcount_r <= reg_wdata[7:0];
        end else if (matched) begin
            rcount_r <= 8'h00;
        end else if (tick) begin
            rcount_r <= rcount_r + 8'h01;
        end
    end

    // Set wins over the clear taken when the refresh starts
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rf_pend_r <= 1'b0;
        end else if (matched && !cnt_wr && auto_on) begin
            rf_pend_r <= 1'b1;
        end else if (state_r == ST_REFRESH_ON || !auto_on) begin
            rf_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign take_idle = (state_r == ST_IDLE) && req_valid && !(is_psram && self_req)
                       && !(is_psram && rf_pend_r);
    assign take_capt = (state_r == ST_CAPT) && req_valid && req.space3 && is_psram
                       && !rf_pend_r && !self_req;
    assign null_done = take_idle && req.space3 && !is_psram;
    assign beat_end  = (state_r == ST_ROMD) && (cnt_r == 3'h0)
                       && ((w0 == 2'h0) || wait_n);
    assign req_taken = take_idle | take_capt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == 3'h0) ? 3'h0 : cnt_r - 3'h1;
        case (state_r)
            ST_IDLE: begin
                if (is_psram && self_req) begin
                    state_nxt = ST_SELF;
                end else if (is_psram && rf_pend_r) begin
                    state_nxt = ST_REFRESH_ON;
                    cnt_nxt   = rf_len - 3'h1;
                end else if (take_idle && !req.space3) begin
                    state_nxt = ST_ROMA;
                end else if (take_idle && !null_done) begin
                    state_nxt = ST_PRE;
                end
            end
            ST_PRE:  state_nxt = memctl_r[MC_STRETCH] ? ST_PREW
                                 : (op_refresh_on_r ? ST_IDLE : ST_SEL);
            ST_PREW: state_nxt = op_refresh_on_r ? ST_IDLE : ST_SEL;
            ST_SEL:  state_nxt = memctl_r[MC_DELAY] ? ST_SELW : ST_STRB;
            ST_SELW: state_nxt = ST_STRB;
            ST_STRB: begin
                if (w3 != 2'h0) begin
                    state_nxt = ST_WAIT;
                    cnt_nxt   = {1'b0, w3} - 3'h1;
                end else begin
                    state_nxt = ST_CAPT;
                end
            end
            ST_WAIT: begin
                if (cnt_r == 3'h0 && wait_n) begin
                    state_nxt = ST_CAPT;
                end
            end
            ST_CAPT: begin
                if (take_capt && memctl_r[MC_BURST] && same_row) begin
                    state_nxt = ST_STRB;
                end else if (take_capt) begin
                    state_nxt = memctl_r[MC_STRETCH] ? ST_PREW : ST_SEL;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_REFRESH_ON: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = ST_PRE;
                end
            end
            ST_SELF: begin
                if (!self_req) begin
                    state_nxt = ST_RECOV;
                    cnt_nxt   = rf_len;
                end
            end
            ST_RECOV: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ROMA: begin
                state_nxt = ST_ROMD;
                cnt_nxt   = {1'b0, w0};
            end
            ST_ROMD: begin
                if (beat_end && beats_r == 3'h1 && longs_r == 2'h0) begin
                    state_nxt = ST_IDLE;
                end else if (beat_end && beats_r == 3'h1) begin
                    state_nxt = ST_ROMA;
                end else if (beat_end && !nibble) begin
                    state_nxt = ST_ROMA;
                end else if (beat_end) begin
                    cnt_nxt = (w0 == 2'h0) ? 3'h1 : {1'b0, w0};
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            op_refresh_on_r <= 1'b0;
        end else if (state_r == ST_REFRESH_ON) begin
            op_refresh_on_r <= 1'b1;
        end else if (state_r == ST_IDLE) begin
            op_refresh_on_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request capture and ROM beat bookkeeping
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            op_r       <= '0;
            rom_addr_r <= 27'h0;
            beats_r    <= 3'h0;
            longs_r    <= 2'h0;
            shift_r    <= 32'h0000_0000;
        end else if (req_taken) begin
            op_r       <= req;
            rom_addr_r <= req.addr;
            // Line fills force longwords; max four per burst
            beats_r    <= beats_of(req.line4 ? 2'h2 : req.size, rom16);
            longs_r    <= req.line4 ? 2'h3 : 2'h0;
            shift_r    <= 32'h0000_0000;
        end else if (beat_end) begin
            shift_r    <= rom16 ? {shift_r[15:0], mem_din[15:0]}
                                : {shift_r[23:0], mem_din[7:0]};
            rom_addr_r <= rom_addr_r + (rom16 ? 27'h2 : 27'h1);
            if (beats_r == 3'h1) begin
                beats_r <= beats_of(2'h2, rom16);
                longs_r <= longs_r - 2'h1;
            end else begin
                beats_r <= beats_r - 3'h1;
            end
        end
    end

    // One answer per longword of a line fill
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            resp_valid_r <= 1'b0;
            resp_rdata_r <= 32'h0000_0000;
        end else if (state_r == ST_CAPT) begin
            resp_valid_r <= 1'b1;
            resp_rdata_r <= op_r.write ? 32'h0000_0000 : mem_din;
        end else if (beat_end && beats_r == 3'h1) begin
            resp_valid_r <= 1'b1;
            resp_rdata_r <= rom16 ? {shift_r[15:0], mem_din[15:0]}
                                  : {shift_r[23:0], mem_din[7:0]};
        end else begin
            resp_valid_r <= null_done;
            resp_rdata_r <= 32'h0000_0000;
        end
    end
    assign resp_valid = resp_valid_r;
    assign resp_rdata = resp_rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin decode from state
    wire logic s3_act = (state_r == ST_SEL) || (state_r == ST_SELW) || (state_r == ST_STRB)
                        || (state_r == ST_WAIT) || (state_r == ST_CAPT);
    wire logic s3_dat = (state_r == ST_STRB) || (state_r == ST_WAIT) || (state_r == ST_CAPT);
    wire logic rom_act = (state_r == ST_ROMA) || (state_r == ST_ROMD);

    always_comb begin
        mem.addr              = rom_act ? rom_addr_r : op_r.addr;
        mem.dout              = op_r.wdata;
        mem.dout_oe           = s3_dat && op_r.write;
        mem.space0_select_n   = !rom_act;
        mem.space3_select_n   = !s3_act;
        mem.oe_refresh_n      = !((s3_dat && !op_r.write) || state_r == ST_REFRESH_ON
                                  || state_r == ST_SELF);
        mem.write_enable_n    = (s3_dat && op_r.write) ? 4'h0 : 4'hF;
        mem.bus_cycle_start_n = !(state_r == ST_STRB || state_r == ST_ROMA);
        mem.read_n            = !((s3_dat && !op_r.write) || state_r == ST_ROMD);
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [2:0] rf_run_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rf_run_r <= 3'h0;
        end else begin
            rf_run_r <= (state_r == ST_REFRESH_ON) ? rf_run_r + 3'h1 : 3'h0;
        end
    end

    refresh_on_len_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_REFRESH_ON && state_nxt != ST_REFRESH_ON) |-> (rf_run_r + 3'h1 == rf_len))
        else $error("refresh strobe length wrong");

    post_refresh_on_pre_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_REFRESH_ON && state_nxt == ST_PRE && memctl_r[MC_STRETCH])
        |=> ##1 (state_r == ST_PREW) ##1 mem.space3_select_n)
        else $error("precharge after refresh not stretched");

    count_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (matched && !cnt_wr) |=> (rcount_r == 8'h00))
        else $error("refresh counter not cleared on match");

    self_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_SELF) |-> (mem.space3_select_n && !mem.oe_refresh_n && !req_taken))
        else $error("access during self refresh");

    exit_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_SELF && !self_req) |=> (mem.space3_select_n && !req_taken)[*2])
        else $error("command during self refresh recovery");

    wait_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_WAIT && cnt_r == 3'h0 && !wait_n) |=> (state_r == ST_WAIT))
        else $error("external wait ignored");

    strb_len_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_STRB && w3 == 2'h2 && wait_n) |=> (state_r == ST_WAIT)
        ##1 (state_r == ST_WAIT || state_r == ST_CAPT))
        else $error("space-3 wait count wrong");

    burst_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_r == ST_CAPT && state_nxt == ST_STRB) |=> !mem.space3_select_n
        && !mem.bus_cycle_start_n && $stable(mem.space3_select_n))
        else $error("select dropped inside burst");

    pend_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rf_pend_r && auto_on && s3_act) |=> rf_pend_r)
        else $error("refresh request lost during access");

    rom_skip_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (beat_end && nibble && beats_r != 3'h1 && w0 == 2'h0) |=> (state_r == ST_ROMD)
        && !mem.space0_select_n ##1 (state_r == ST_ROMD))
        else $error("nibble beat not two cycles");

endmodule
`default_nettype wire

// [pbri_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pbri_mem_model
    import pbri_pkg::*;
(
    // Clock, pins from the controller and the stall setting
    input  wire logic        core_clk,
    input  wire pbri_pins_t  mem,
    input  wire logic [2:0]  stall,
    // Answers to the controller
    output logic      [31:0] mem_din,
    output logic             wait_n
);
    logic [31:0] arr [16];
    logic [31:0] last  = 32'h0;
    logic [2:0]  left  = 3'h0;
    logic        armed = 1'b0;
    logic [7:0]  rom_b;

    assign rom_b = 8'hA0 | {4'h0, mem.addr[3:0]};
    // Released bus toggles so a stale sample never passes
    always_comb begin
        if (!mem.space0_select_n) mem_din = {4{rom_b}};
        else if (!mem.space3_select_n && &mem.write_enable_n) mem_din = arr[mem.addr[5:2]];
        else mem_din = ~last;
    end
    always_ff @(posedge core_clk) begin
        last <= mem_din;
        if (!mem.space3_select_n && !(&mem.write_enable_n)) arr[mem.addr[5:2]] <= mem.dout;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Wait held low for stall cycles after each strobe
    always_ff @(posedge core_clk) begin
        if (mem.bus_cycle_start_n) armed <= 1'b0;
        if (!mem.bus_cycle_start_n && !armed) begin
            left  <= stall;
            armed <= 1'b1;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end
    end
    assign wait_n = (left == 3'h0);
endmodule
`default_nettype wire

// [pbri_pkg.sv]
package pbri_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] REG_MEMCTL   = 3'h0;
    localparam logic [2:0] REG_WAITCTL  = 3'h1;
    localparam logic [2:0] REG_BUSCTL   = 3'h2;
    localparam logic [2:0] REG_RTCTL    = 3'h3;
    localparam logic [2:0] REG_RCOUNT   = 3'h4;
    localparam logic [2:0] REG_RMATCH   = 3'h5;
    localparam logic [2:0] REG_STATUS   = 3'h6;

    // Field positions
    localparam int MC_STRETCH = 0;
    localparam int MC_DELAY   = 1;
    localparam int MC_BURST   = 2;
    localparam int MC_KIND    = 3;
    localparam int MC_ON      = 4;
    localparam int MC_LEN     = 5;
    localparam int BC_NIBBLE  = 3;
    localparam int BC_ROM16   = 4;

    // Reset values
    localparam logic [5:0] MEMCTL_RST  = 6'h00;
    localparam logic [3:0] WAITCTL_RST = 4'hF;
    localparam logic [4:0] BUSCTL_RST  = 5'h00;
    localparam logic [7:0] RCOUNT_RST  = 8'h00;
    localparam logic [7:0] RMATCH_RST  = 8'h00;

    localparam logic [2:0] TYPE_PSRAM  = 3'h3;
    localparam int         ROW_LSB     = 10;

    // Refresh strobe lengths and largest space-3 waits
    localparam logic [2:0] RF_LEN_SHORT = 3'h2;
    localparam logic [2:0] RF_LEN_LONG  = 3'h4;
    localparam logic [1:0] S3_WAIT_MAX  = 2'h2;

    // Prescaler tick masks for clock select 1..7
    localparam logic [11:0] DIV_MASK [8] = '{12'h000, 12'h003, 12'h00F, 12'h03F,
                                             12'h0FF, 12'h3FF, 12'h7FF, 12'hFFF};

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_PRE   = 4'b0001,
        ST_PREW  = 4'b0010,
        ST_SEL   = 4'b0011,
        ST_SELW  = 4'b0100,
        ST_STRB  = 4'b0101,
        ST_WAIT  = 4'b0110,
        ST_CAPT  = 4'b0111,
        ST_REFRESH_ON  = 4'b1000,
        ST_SELF  = 4'b1001,
        ST_RECOV = 4'b1010,
        ST_ROMA  = 4'b1011,
        ST_ROMD  = 4'b1100
    } pbri_state_t;

    typedef struct packed {
        logic        write;
        logic        space3;
        logic [1:0]  size;
        logic        line4;
        logic [26:0] addr;
        logic [31:0] wdata;
    } pbri_req_t;

    typedef struct packed {
        logic [26:0] addr;
        logic [31:0] dout;
        logic        dout_oe;
        logic        space0_select_n;
        logic        space3_select_n;
        logic        oe_refresh_n;
        logic [3:0]  write_enable_n;
        logic        bus_cycle_start_n;
        logic        read_n;
    } pbri_pins_t;

endpackage

// [psram_and_burst_rom_interface_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module psram_and_burst_rom_interface_tb
    import pbri_pkg::*;
;
    logic        core_clk  = 1'b0;
    logic        resetn    = 1'b0;
    logic [2:0]  reg_addr  = 3'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        req_valid = 1'b0;
    logic [2:0]  stall     = 3'h0;
    pbri_req_t   req       = '0;
    logic [31:0] reg_rdata, resp_rdata, mem_din, got, v;
    logic        req_taken, resp_valid, wait_n;
    pbri_pins_t  mem;
    int          err_total = 0, checks_done = 0, lat, n_low;
    logic [31:0] rst_v [8] = '{32'h0, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    // Psram cases: memctl, waitctl, stall, latency
    int          pm [7] = '{0, 1, 2, 0, 0, 0, 0};
    int          pw [7] = '{0, 0, 0, 1, 2, 1, 0};
    int          ps [7] = '{0, 0, 0, 0, 0, 2, 2};
    int          pl [7] = '{5, 6, 6, 6, 7, 8, 5};
    // Rom cases: busctl, waitctl, size, latency, data
    int          rb [4] = '{8'h0B, 8'h03, 8'h1B, 8'h0B};
    int          rw [4] = '{4, 4, 4, 0};
    int          rs [4] = '{1, 1, 2, 1};
    int          rl [4] = '{6, 7, 6, 5};
    logic [31:0] rd_x [4] = '{32'hA0A1, 32'hA0A1, 32'hA0A0A2A2, 32'hA0A1};

    always #12.5 core_clk = ~core_clk;

    pbri_ctrl pbri_ctrl_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .req, .req_valid, .req_taken, .resp_valid, .resp_rdata, .mem,
        .mem_din, .wait_n);
    pbri_mem_model pbri_mem_model_i (.core_clk, .mem, .stall, .mem_din, .wait_n);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input int d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= 32'(d);
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Latency counts cycles from the taking edge to the last answer
    task automatic xfer(input logic w, s3, input int sz, input logic l4, input int a, d, n);
        int k, c;
        k = 0;
        c = 1;
        @(posedge core_clk);
        req       <= pbri_req_t'{w, s3, 2'(sz), l4, 27'(a), 32'(d)};
        req_valid <= 1'b1;
        @(negedge core_clk);
        while (req_taken !== 1'b1 && k < 300) begin @(negedge core_clk); k++; end
        @(posedge core_clk);
        req_valid <= 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            while (resp_valid !== 1'b1 && c < 300) begin @(negedge core_clk); c++; end
            got = resp_rdata;
            lat = c;
            @(posedge core_clk);
            c++;
        end
        if (c >= 300 || k >= 300) `CHK("handshake", 1, 0)
    endtask
    task automatic strobe_len(output int n);
        int k;
        k = 0;
        n = 0;
        @(negedge core_clk);
        while (!mem.oe_refresh_n && k < 50) begin @(negedge core_clk); k++; end
        while (mem.oe_refresh_n && k < 300) begin @(negedge core_clk); k++; end
        while (!mem.oe_refresh_n && n < 9) begin @(negedge core_clk); n++; end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (rst_v[i]) begin rd(3'(i)); `CHK("reset value", rst_v[i], v) end
        $display("reset test done");
        wr(REG_BUSCTL, 3);
        xfer(1, 1, 2, 0, 8, 32'h5A5A1234, 1);
        foreach (pm[i]) begin
            wr(REG_MEMCTL, pm[i]);
            wr(REG_WAITCTL, pw[i]);
            stall <= 3'(ps[i]);
            xfer(0, 1, 2, 0, 8, 0, 1);
            `CHK("psram latency", pl[i], lat)
            `CHK("psram data", 32'h5A5A1234, got)
        end
        stall <= 3'h0;
        $display("psram timing test done");
        wr(REG_BUSCTL, 0);
        xfer(0, 1, 2, 0, 8, 0, 1);
        `CHK("refused latency", 1, lat)
        `CHK("refused data", 32'h0, got)
        // Match, counter and modes go in before the clock select
        wr(REG_BUSCTL, 3);
        wr(REG_RMATCH, 3);
        wr(REG_RCOUNT, 0);
        for (int j = 0; j < 2; j++) begin
            wr(REG_MEMCTL, j ? 32'h30 : 32'h10);
            wr(REG_RTCTL, 1);
            strobe_len(n_low);
            `CHK("refresh strobe", j ? 4 : 2, n_low)
        end
        wr(REG_RTCTL, 0);
        wr(REG_MEMCTL, 32'h18);
        rd(REG_STATUS);
        `CHK("self refresh flag", 32'h3, v)
        @(posedge core_clk);
        req       <= pbri_req_t'{1'b0, 1'b1, 2'h2, 1'b0, 27'h8, 32'h0};
        req_valid <= 1'b1;
        repeat (8) begin @(negedge core_clk); `CHK("taken in self", 1'b0, req_taken) end
        // Withdraw the refused request so the exit is not met by a stale one
        @(posedge core_clk);
        req_valid <= 1'b0;
        wr(REG_MEMCTL, 0);
        xfer(0, 1, 2, 0, 8, 0, 1);
        `CHK("read after self", 32'h5A5A1234, got)
        $display("refresh test done");
        foreach (rb[i]) begin
            wr(REG_BUSCTL, rb[i]);
            wr(REG_WAITCTL, rw[i]);
            xfer(0, 0, rs[i], 0, 32'h10, 0, 1);
            `CHK("rom latency", rl[i], lat)
            `CHK("rom data", rd_x[i], got)
        end
        xfer(0, 0, 2, 1, 32'h10, 0, 4);
        `CHK("line fill last word", 32'hACADAEAF, got)
        // ROM holds wait low for two cycles of the first beat
        wr(REG_BUSCTL, 8'h0B);
        wr(REG_WAITCTL, 4);
        stall <= 3'h2;
        xfer(0, 0, 1, 0, 32'h10, 0, 1);
        stall <= 3'h0;
        `CHK("rom wait latency", 7, lat)
        `CHK("rom wait data", 32'hA0A1, got)
        $display("burst rom test done");
        print_verdict;
    end
    initial begin
        #(25 * 20000);
        err_total++;
        print_verdict;
    end
endmodule
`default_nettype wire
